// file: hdl/ecru_reset_map.vh
// Constants of the Ethernet controller reset unit: register offsets, bit
// positions, reset values and delay counts.
// Assumes a 25 MHz core clock and a 32-bit AXI4-Lite register bus.
// Operation
// - Five reset kinds exist: power-on, system, transmit-only, receive-only, PHY.
// - Power-on reset is always active; nothing can disable it.
// - Power-on reset loads every register default; memories stay undefined.
// - System reset restores all registers except clock-output frequency field; the code also leaves bank select unchanged without the serial interface.
// - System reset clears transmit, receive, MAC, PHY, DMA and crypto logic.
// - With serial host interface, system reset returns bank selection to zero.
// - System reset leaves packet buffer, crypto memories, address latch untouched.
// - Host writes one to start system reset; hardware clears the bit.
// - System reset does not resample interface selection pins.
// - Transmit logic held in reset while transmit-only reset bit set.
// - Transmit-only reset aborts transmission and clears transmit request bit.
// - Power-on and system resets include transmit-only and receive-only resets.
// - Receive-only reset holds receive logic, aborts frame, clears receive enable.
// - PHY reset bit resets PHY and its registers, nothing else.
// - PHY reset bit self-clears after a delay; software cannot clear it.
// - Power-on and system resets include a full PHY reset.
// - Clock-output frequency defaults after power-on, survives all other resets.
`ifndef ECRU_RESET_MAP_VH
`define ECRU_RESET_MAP_VH

// -----------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------
`define ECRU_OFS_CTRL_ONE    8'h00
`define ECRU_OFS_CTRL_TWO    8'h04
`define ECRU_OFS_PHY_CTRL    8'h08
`define ECRU_OFS_STATUS      8'h0c
`define ECRU_OFS_BANK        8'h10

// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define ECRU_BIT_RX_ENABLE   0
`define ECRU_BIT_TX_REQUEST  1
`define ECRU_BIT_PKT_DEC     8
`define ECRU_BIT_SYS_RESET   4
`define ECRU_BIT_RX_RESET    5
`define ECRU_BIT_TX_RESET    6
`define ECRU_FREQ_MSB        11
`define ECRU_FREQ_LSB        8
`define ECRU_BIT_PHY_RESET   15
`define ECRU_STAT_PHY_BUSY   8
`define ECRU_STAT_SERIAL     9
`define ECRU_STAT_CFG_LSB    10

// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define ECRU_FREQ_DEFAULT    4'h1
`define ECRU_BANK_DEFAULT    2'h0
`define ECRU_COUNT_DEFAULT   8'h00

// -----------------------------------------------------------------
// Timing
// -----------------------------------------------------------------
// Sized to 16 bits so the counts load the timers without truncation
`define ECRU_CLKS_PER_US     16'h0019
`define ECRU_SYS_HOLD_US     16'h0019
`define ECRU_PHY_HOLD_US     16'h0100
`define ECRU_SYS_HOLD_CYCLES (`ECRU_SYS_HOLD_US * `ECRU_CLKS_PER_US)
`define ECRU_PHY_HOLD_CYCLES (`ECRU_PHY_HOLD_US * `ECRU_CLKS_PER_US)

// -----------------------------------------------------------------
// Bus answers
// -----------------------------------------------------------------
`define ECRU_RESP_OKAY       2'h0
`define ECRU_RESP_SLVERR     2'h2

`endif

// file: hdl/ecru_delay_timer.v
// Down-counter that stays busy for a loaded number of clock-enabled core clock cycles.
// Assumes start arrives from logic on the same clock; start acts even
// while the clock enable is low so that power-on reset always loads it.
`timescale 1ns/1ps
`default_nettype none

module ecru_delay_timer (
  input  wire        clk,
  input  wire        clkEn,
  input  wire        start,
  input  wire [15:0] length,
  output wire        busy
);

  reg [15:0] count_q;

  always @(posedge clk) begin
    if (start) begin
      count_q <= length;
    end else if (clkEn && count_q != 16'h0000) begin
      count_q <= count_q - 16'h0001;
    end
  end

  assign busy = (count_q != 16'h0000);

endmodule

`default_nettype wire

// file: hdl/ecru_reset_unit.v
// Reset sequencer of the Ethernet controller with its control registers.
// Assumes an AXI4-Lite master on core_clk and interface straps from pins.
//
// Implementation choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "ecru_reset_map.vh"

module ecru_reset_unit #(
  parameter [15:0] PHY_HOLD_CYCLES = `ECRU_PHY_HOLD_CYCLES
) (
  input  wire        core_clk,
  input  wire        rst,
  input  wire        clkEn,
  input  wire        serialInterfaceSelectPin,
  input  wire [2:0]  parallelModeConfigPins,
  input  wire        txDoneIn,
  input  wire        rxPacketIn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  output wire        txLogicReset,
  output wire        rxLogicReset,
  output wire        macLogicReset,
  output wire        phyLogicReset,
  output wire        dmaLogicReset,
  output wire        cryptoLogicReset,
  output wire        transmitRequest,
  output wire        receiveEnableBit,
  output wire [3:0]  clockOutputFrequencySelect,
  output wire [1:0]  bankSelect,
  output wire        serialInterfaceActive,
  output wire [2:0]  parallelModeConfig
);

  localparam [15:0] SYS_HOLD_CYCLES = `ECRU_SYS_HOLD_CYCLES;

  // -----------------------------------------------------------------
  // State
  // -----------------------------------------------------------------
  reg        awReady_q;
  reg        wReady_q;
  reg [7:0]  awAddr_q;
  reg [31:0] wData_q;
  reg [3:0]  wStrb_q;
  reg        bValid_q;
  reg [1:0]  bResp_q;
  reg        arReady_q;
  reg        rValid_q;
  reg [31:0] rData_q;
  reg [1:0]  rResp_q;

  reg        receiveEnableBit_q;
  reg        transmitRequest_q;
  reg        rxOnlyReset_q;
  reg        txOnlyReset_q;
  reg [3:0]  freqSel_q;
  reg [1:0]  bankSel_q;
  reg [7:0]  pendingPacketCount_q;

  reg        serialSel_s1;
  reg        serialSel_s2;
  reg [2:0]  cfg_s1;
  reg [2:0]  cfg_s2;
  reg [1:0]  strapCnt_q;
  reg        serialActive_q;
  reg [2:0]  parallelCfg_q;

  reg        txLogicReset_q;
  reg        rxLogicReset_q;
  reg        macLogicReset_q;
  reg        phyLogicReset_q;
  reg        dmaLogicReset_q;
  reg        cryptoLogicReset_q;

  wire       sysBusy;
  wire       phyBusy;
  wire       wrFire;
  wire       sysStart;
  wire       phyStart;
  wire       decPulse;
  wire       regsInReset;
  reg [31:0] rdMux;
  reg        rdHit;

  // -----------------------------------------------------------------
  // Delay timers
  // -----------------------------------------------------------------
  // Power-on reset is the rst input itself and cannot be gated.
  ecru_delay_timer uSysTimer (
    .clk    (core_clk),
    .clkEn  (clkEn),
    .start  (rst | sysStart),
    .length (SYS_HOLD_CYCLES),
    .busy   (sysBusy)
  );

  // PHY reset also runs after power-on and system reset.
  ecru_delay_timer uPhyTimer (
    .clk    (core_clk),
    .clkEn  (clkEn),
    .start  (rst | sysStart | phyStart),
    .length (PHY_HOLD_CYCLES),
    .busy   (phyBusy)
  );

  // -----------------------------------------------------------------
  // Write decode
  // -----------------------------------------------------------------
  assign wrFire = clkEn & ~awReady_q & ~wReady_q & ~bValid_q;

  // Writing one starts the system reset; its bit reads the busy timer.
  assign sysStart = wrFire & ~sysBusy & (awAddr_q == `ECRU_OFS_CTRL_TWO)
                  & wStrb_q[0] & wData_q[`ECRU_BIT_SYS_RESET];

  // A written zero never ends the PHY reset early.
  assign phyStart = wrFire & ~sysBusy & ~phyBusy & (awAddr_q == `ECRU_OFS_PHY_CTRL)
                  & wStrb_q[1] & wData_q[`ECRU_BIT_PHY_RESET];

  assign decPulse = wrFire & (awAddr_q == `ECRU_OFS_CTRL_ONE)
                  & wStrb_q[1] & wData_q[`ECRU_BIT_PKT_DEC];

  // Registers stay at defaults for the whole system reset hold.
  assign regsInReset = rst | (clkEn & sysBusy);

  // -----------------------------------------------------------------
  // AXI4-Lite write channels
  // -----------------------------------------------------------------
  always @(posedge core_clk) begin
    if (rst) begin
      awReady_q <= 1'b1;
      wReady_q  <= 1'b1;
      awAddr_q  <= 8'h00;
      wData_q   <= 32'h0000_0000;
      wStrb_q   <= 4'h0;
      bValid_q  <= 1'b0;
      bResp_q   <= `ECRU_RESP_OKAY;
    end else if (clkEn) begin
      if (awReady_q && s_axi_awvalid) begin
        awReady_q <= 1'b0;
        awAddr_q  <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (wReady_q && s_axi_wvalid) begin
        wReady_q <= 1'b0;
        wData_q  <= s_axi_wdata;
        wStrb_q  <= s_axi_wstrb;
      end
      if (wrFire) begin
        awReady_q <= 1'b1;
        wReady_q  <= 1'b1;
        bValid_q  <= 1'b1;
        bResp_q   <= (awAddr_q <= `ECRU_OFS_BANK) ? `ECRU_RESP_OKAY : `ECRU_RESP_SLVERR;
      end else if (bValid_q && s_axi_bready) begin
        bValid_q <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------
  // AXI4-Lite read channels
  // -----------------------------------------------------------------
  always @* begin
    rdMux = 32'h0000_0000;
    rdHit = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      `ECRU_OFS_CTRL_ONE: begin
        rdMux[`ECRU_BIT_RX_ENABLE]  = receiveEnableBit_q;
        rdMux[`ECRU_BIT_TX_REQUEST] = transmitRequest_q;
      end
      `ECRU_OFS_CTRL_TWO: begin
        rdMux[`ECRU_BIT_SYS_RESET] = sysBusy;
        rdMux[`ECRU_BIT_RX_RESET]  = rxOnlyReset_q;
        rdMux[`ECRU_BIT_TX_RESET]  = txOnlyReset_q;
        rdMux[`ECRU_FREQ_MSB:`ECRU_FREQ_LSB] = freqSel_q;
      end
      `ECRU_OFS_PHY_CTRL: begin
        rdMux[`ECRU_BIT_PHY_RESET] = phyBusy;
      end
      `ECRU_OFS_STATUS: begin
        rdMux[7:0] = pendingPacketCount_q;
        rdMux[`ECRU_STAT_PHY_BUSY] = phyBusy;
        rdMux[`ECRU_STAT_SERIAL]   = serialActive_q;
        rdMux[`ECRU_STAT_CFG_LSB+2:`ECRU_STAT_CFG_LSB] = parallelCfg_q;
      end
      `ECRU_OFS_BANK: begin
        rdMux[1:0] = bankSel_q;
      end
      default: begin
        rdHit = 1'b0;
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (rst) begin
      arReady_q <= 1'b1;
      rValid_q  <= 1'b0;
      rData_q   <= 32'h0000_0000;
      rResp_q   <= `ECRU_RESP_OKAY;
    end else if (clkEn) begin
      if (arReady_q && s_axi_arvalid) begin
        arReady_q <= 1'b0;
        rValid_q  <= 1'b1;
        rData_q   <= rdMux;
        rResp_q   <= rdHit ? `ECRU_RESP_OKAY : `ECRU_RESP_SLVERR;
      end else if (rValid_q && s_axi_rready) begin
        rValid_q  <= 1'b0;
        arReady_q <= 1'b1;
      end
    end
  end

  // -----------------------------------------------------------------
  // Control registers
  // -----------------------------------------------------------------
  // Packet buffer and crypto memories live outside and see no reset here.
  always @(posedge core_clk) begin
    if (regsInReset) begin
      receiveEnableBit_q <= 1'b0;
      transmitRequest_q  <= 1'b0;
      rxOnlyReset_q      <= 1'b0;
      txOnlyReset_q      <= 1'b0;
      pendingPacketCount_q <= `ECRU_COUNT_DEFAULT;
    end else if (clkEn) begin
      if (wrFire && awAddr_q == `ECRU_OFS_CTRL_ONE && wStrb_q[0]) begin
        receiveEnableBit_q <= wData_q[`ECRU_BIT_RX_ENABLE];
        transmitRequest_q  <= wData_q[`ECRU_BIT_TX_REQUEST];
      end
      if (wrFire && awAddr_q == `ECRU_OFS_CTRL_TWO && wStrb_q[0]) begin
        rxOnlyReset_q <= wData_q[`ECRU_BIT_RX_RESET];
        txOnlyReset_q <= wData_q[`ECRU_BIT_TX_RESET];
      end
      // Completion clears the request only when software is not setting it.
      if (txDoneIn && !(wrFire && awAddr_q == `ECRU_OFS_CTRL_ONE && wStrb_q[0])) begin
        transmitRequest_q <= 1'b0;
      end
      if (txOnlyReset_q) begin
        transmitRequest_q <= 1'b0;
      end
      if (rxOnlyReset_q) begin
        receiveEnableBit_q <= 1'b0;
      end
      // Receive-only reset keeps the count; software drains it by decrements.
      if (rxPacketIn && !decPulse && pendingPacketCount_q != 8'hff) begin
        pendingPacketCount_q <= pendingPacketCount_q + 8'h01;
      end else if (decPulse && !rxPacketIn && pendingPacketCount_q != 8'h00) begin
        pendingPacketCount_q <= pendingPacketCount_q - 8'h01;
      end
    end
  end

  // Frequency select survives every reset but power-on.
  always @(posedge core_clk) begin
    if (rst) begin
      freqSel_q <= `ECRU_FREQ_DEFAULT;
    end else if (clkEn && wrFire && !sysBusy && awAddr_q == `ECRU_OFS_CTRL_TWO && wStrb_q[1]) begin
      freqSel_q <= wData_q[`ECRU_FREQ_MSB:`ECRU_FREQ_LSB];
    end
  end

  // Bank select returns to zero on system reset only over the serial link.
  always @(posedge core_clk) begin
    if (rst) begin
      bankSel_q <= `ECRU_BANK_DEFAULT;
    end else if (clkEn && sysBusy && serialActive_q) begin
      bankSel_q <= `ECRU_BANK_DEFAULT;
    end else if (clkEn && wrFire && awAddr_q == `ECRU_OFS_BANK && wStrb_q[0]) begin
      bankSel_q <= wData_q[1:0];
    end
  end

  // -----------------------------------------------------------------
  // Interface straps
  // -----------------------------------------------------------------
  always @(posedge core_clk) begin
    serialSel_s1 <= serialInterfaceSelectPin;
    serialSel_s2 <= serialSel_s1;
    cfg_s1       <= parallelModeConfigPins;
    cfg_s2       <= cfg_s1;
  end

  // Straps latch only after power-on release, never on system reset.
  always @(posedge core_clk) begin
    if (rst) begin
      strapCnt_q     <= 2'd0;
      serialActive_q <= 1'b0;
      parallelCfg_q  <= 3'h0;
    end else if (clkEn && strapCnt_q != 2'd3) begin
      strapCnt_q <= strapCnt_q + 2'd1;
      if (strapCnt_q == 2'd2) begin
        serialActive_q <= serialSel_s2;
        parallelCfg_q  <= cfg_s2;
      end
    end
  end

  // -----------------------------------------------------------------
  // Reset outputs
  // -----------------------------------------------------------------
  // Registered so each domain enters and leaves reset on a clock edge.
  always @(posedge core_clk) begin
    if (rst) begin
      txLogicReset_q     <= 1'b1;
      rxLogicReset_q     <= 1'b1;
      macLogicReset_q    <= 1'b1;
      phyLogicReset_q    <= 1'b1;
      dmaLogicReset_q    <= 1'b1;
      cryptoLogicReset_q <= 1'b1;
    end else if (clkEn) begin
      txLogicReset_q     <= sysBusy | txOnlyReset_q;
      rxLogicReset_q     <= sysBusy | rxOnlyReset_q;
      macLogicReset_q    <= sysBusy;
      phyLogicReset_q    <= phyBusy;
      dmaLogicReset_q    <= sysBusy;
      cryptoLogicReset_q <= sysBusy;
    end
  end

  // -----------------------------------------------------------------
  // Output wiring
  // -----------------------------------------------------------------
  assign s_axi_awready = awReady_q;
  assign s_axi_wready  = wReady_q;
  assign s_axi_bvalid  = bValid_q;
  assign s_axi_bresp   = bResp_q;
  assign s_axi_arready = arReady_q;
  assign s_axi_rvalid  = rValid_q;
  assign s_axi_rdata   = rData_q;
  assign s_axi_rresp   = rResp_q;

  assign txLogicReset     = txLogicReset_q;
  assign rxLogicReset     = rxLogicReset_q;
  assign macLogicReset    = macLogicReset_q;
  assign phyLogicReset    = phyLogicReset_q;
  assign dmaLogicReset    = dmaLogicReset_q;
  assign cryptoLogicReset = cryptoLogicReset_q;

  assign transmitRequest            = transmitRequest_q;
  assign receiveEnableBit           = receiveEnableBit_q;
  assign clockOutputFrequencySelect = freqSel_q;
  assign bankSelect                 = bankSel_q;
  assign serialInterfaceActive      = serialActive_q;
  assign parallelModeConfig         = parallelCfg_q;

endmodule

`default_nettype wire

// file: testbench/ecru_reset_checker.sv
// Port-level checker of the Ethernet controller reset unit.
// Assumes it is bound into ecru_reset_unit and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module ecru_reset_checker #(
  parameter [15:0] PHY_HOLD_CYCLES = 16'd20
) (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       clkEn,
  input wire logic       txLogicReset,
  input wire logic       rxLogicReset,
  input wire logic       macLogicReset,
  input wire logic       phyLogicReset,
  input wire logic       dmaLogicReset,
  input wire logic       cryptoLogicReset,
  input wire logic       transmitRequest,
  input wire logic       receiveEnableBit,
  input wire logic [3:0] clockOutputFrequencySelect,
  input wire logic [1:0] bankSelect,
  input wire logic       serialInterfaceActive,
  input wire logic [2:0] parallelModeConfig
);
  localparam int SysMax = 640;
  localparam int PhyMax = 640 + PHY_HOLD_CYCLES;
  logic [15:0] sysCnt_q;
  logic [15:0] phyCnt_q;

  default clocking cb @(posedge core_clk); endclocking

  // ----------------------------------------
  // Hold counters
  // ----------------------------------------
  // Holds run for hundreds of cycles, too long for a repetition
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sysCnt_q <= 16'h0000;
      phyCnt_q <= 16'h0000;
    end else if (clkEn) begin
      sysCnt_q <= macLogicReset ? sysCnt_q + 16'h0001 : 16'h0000;
      phyCnt_q <= phyLogicReset ? phyCnt_q + 16'h0001 : 16'h0000;
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_tx_hold;
    disable iff (rst) txLogicReset && $past(txLogicReset) |-> !transmitRequest;
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("transmit request set in transmit reset");

  property p_rx_hold;
    disable iff (rst) rxLogicReset && $past(rxLogicReset) |-> !receiveEnableBit;
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("receive enable set in receive reset");

  property p_sys_group;
    disable iff (rst) macLogicReset == dmaLogicReset && macLogicReset == cryptoLogicReset;
  endproperty
  a_sys_group: assert property (p_sys_group) else $error("system reset group split");

  property p_sys_includes;
    disable iff (rst) macLogicReset && $past(macLogicReset) |-> txLogicReset && rxLogicReset;
  endproperty
  a_sys_includes: assert property (p_sys_includes) else $error("tx or rx free in system reset");

  property p_phy_includes;
    disable iff (rst) $rose(macLogicReset) |-> ##[0:2] phyLogicReset;
  endproperty
  a_phy_includes: assert property (p_phy_includes) else $error("system reset missed phy");

  property p_freq_keep;
    disable iff (rst) $rose(macLogicReset) |-> $stable(clockOutputFrequencySelect);
  endproperty
  a_freq_keep: assert property (p_freq_keep) else $error("frequency lost on system reset");

  property p_por_defaults;
    disable iff (rst) $fell(rst) |-> clockOutputFrequencySelect == 4'h1 && bankSelect == 2'h0
      && !transmitRequest && !receiveEnableBit;
  endproperty
  a_por_defaults: assert property (p_por_defaults) else $error("defaults wrong after power-on");

  property p_straps;
    disable iff (rst) $rose(macLogicReset) |=> ($stable(serialInterfaceActive) && $stable(parallelModeConfig))[*8];
  endproperty
  a_straps: assert property (p_straps) else $error("straps relatched by system reset");

  property p_por_always;
    rst |=> txLogicReset && rxLogicReset && macLogicReset && phyLogicReset;
  endproperty
  a_por_always: assert property (p_por_always) else $error("power-on reset not applied");

  property p_sys_bound;
    disable iff (rst) sysCnt_q <= SysMax;
  endproperty
  a_sys_bound: assert property (p_sys_bound) else $error("system reset never self-clears");

  property p_phy_bound;
    disable iff (rst) phyCnt_q <= PhyMax;
  endproperty
  a_phy_bound: assert property (p_phy_bound) else $error("phy reset never self-clears");
endmodule

bind ecru_reset_unit ecru_reset_checker #(.PHY_HOLD_CYCLES(PHY_HOLD_CYCLES)) u_chk (
  .core_clk(core_clk), .rst(rst), .clkEn(clkEn), .txLogicReset(txLogicReset), .rxLogicReset(rxLogicReset),
  .macLogicReset(macLogicReset), .phyLogicReset(phyLogicReset), .dmaLogicReset(dmaLogicReset),
  .cryptoLogicReset(cryptoLogicReset), .transmitRequest(transmitRequest), .receiveEnableBit(receiveEnableBit),
  .clockOutputFrequencySelect(clockOutputFrequencySelect), .bankSelect(bankSelect),
  .serialInterfaceActive(serialInterfaceActive), .parallelModeConfig(parallelModeConfig));
`default_nettype wire

// file: testbench/testbench.sv
// Self-checking bench of the reset unit, driven over AXI4-Lite.
// Assumes the register map header and a 25 MHz core clock.
`timescale 1ns/1ps
`default_nettype none
`include "ecru_reset_map.vh"

module testbench;
  logic        core_clk, rst, clkEn, serPin, txDone, rxPkt;
  logic [2:0]  cfgPins, cfgAct;
  logic [7:0]  awAddr, arAddr;
  logic [31:0] wData, rData, d;
  logic [3:0]  wStrb, freq;
  logic        awValid, wValid, bReady, arValid, rReady;
  logic        awReady, wReady, bValid, arReady, rValid;
  logic [1:0]  bResp, rResp, lastResp, bank;
  logic        transmit_only_reset, receive_only_reset, macRst, phyRst, dmaRst, cryptoRst, txReq, receive_enable_bit, serAct;
  int          err_total, check_count, cycles, n;

  ecru_reset_unit #(.PHY_HOLD_CYCLES(16'd20)) dut (
    .core_clk(core_clk), .rst(rst), .clkEn(clkEn), .serialInterfaceSelectPin(serPin),
    .parallelModeConfigPins(cfgPins), .txDoneIn(txDone), .rxPacketIn(rxPkt),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
    .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
    .s_axi_rready(rReady), .txLogicReset(transmit_only_reset), .rxLogicReset(receive_only_reset), .macLogicReset(macRst),
    .phyLogicReset(phyRst), .dmaLogicReset(dmaRst), .cryptoLogicReset(cryptoRst),
    .transmitRequest(txReq), .receiveEnableBit(receive_enable_bit), .clockOutputFrequencySelect(freq),
    .bankSelect(bank), .serialInterfaceActive(serAct), .parallelModeConfig(cfgAct));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic report_and_stop();
    if (err_total == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
  endtask

  // Entered just after a rising edge; holds each channel until its ready
  // Response readies stay high, so back-to-back calls never toggle them
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic awPend;
    logic wPend;
    awPend = 1'b1;
    wPend = 1'b1;
    awAddr <= a;
    wData <= v;
    awValid <= 1'b1;
    wValid <= 1'b1;
    while (awPend || wPend) begin
      @(posedge core_clk);
      if (awPend && awReady === 1'b1) begin
        awPend = 1'b0;
        awValid <= 1'b0;
      end
      if (wPend && wReady === 1'b1) begin
        wPend = 1'b0;
        wValid <= 1'b0;
      end
    end
    while (bValid !== 1'b1)
      @(posedge core_clk);
    lastResp = bResp;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    arAddr <= a;
    arValid <= 1'b1;
    do @(posedge core_clk); while (arReady !== 1'b1);
    arValid <= 1'b0;
    while (rValid !== 1'b1)
      @(posedge core_clk);
    v = rData;
    lastResp = rResp;
  endtask

  // Host must not touch the unit while the reset hold runs
  task automatic wait_quiet();
    while (macRst !== 1'b0 || phyRst !== 1'b0)
      @(posedge core_clk);
    tick(1);
  endtask

  // ----------------------------------------
  // Clock and timeout
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      err_total = err_total + 1;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    {err_total, check_count, cycles} = {32'd0, 32'd0, 32'd0};
    {rst, clkEn, serPin, cfgPins, txDone, rxPkt} = {3'b111, 3'h5, 2'b00};
    {awAddr, arAddr, wData, wStrb} = {8'h00, 8'h00, 32'h0, 4'hf};
    {awValid, wValid, bReady, arValid, rReady} = 5'b00101;
    tick(12);
    rst <= 1'b0;
    wait_quiet();
    cmp(32'(freq), 32'h1);
    rd(`ECRU_OFS_STATUS, d);
    cmp(d & 32'h1fff, 32'h1600);
    wr(`ECRU_OFS_CTRL_ONE, 32'h3);
    txDone <= 1'b1;
    tick(1);
    txDone <= 1'b0;
    tick(1);
    cmp(32'({txReq, receive_enable_bit}), 32'h1);
    wr(`ECRU_OFS_CTRL_ONE, 32'h3);
    cmp(32'({txReq, receive_enable_bit}), 32'h3);
    wr(`ECRU_OFS_CTRL_TWO, 32'h140);
    tick(2);
    cmp(32'({transmit_only_reset, txReq, receive_only_reset, receive_enable_bit, macRst}), 32'b10010);
    wr(`ECRU_OFS_CTRL_TWO, 32'h100);
    tick(2);
    cmp(32'(transmit_only_reset), 32'h0);
    rxPkt <= 1'b1;
    tick(3);
    rxPkt <= 1'b0;
    wr(`ECRU_OFS_CTRL_TWO, 32'h120);
    tick(2);
    cmp(32'({receive_only_reset, receive_enable_bit, transmit_only_reset}), 32'b100);
    rd(`ECRU_OFS_STATUS, d);
    cmp(d & 32'hff, 32'h3);
    wr(`ECRU_OFS_CTRL_TWO, 32'h100);
    for (n = 0; n < 4; n++)
      wr(`ECRU_OFS_CTRL_ONE, 32'h100);
    rd(`ECRU_OFS_STATUS, d);
    cmp(d & 32'hff, 32'h0);
    wr(`ECRU_OFS_PHY_CTRL, 32'h8000);
    wr(`ECRU_OFS_PHY_CTRL, 32'h0);
    cmp(32'({phyRst, macRst, transmit_only_reset, receive_only_reset}), 32'b1000);
    rd(`ECRU_OFS_PHY_CTRL, d);
    cmp(d & 32'h8000, 32'h8000);
    n = 0;
    while (d[15] !== 1'b0 && n < 50) begin
      rd(`ECRU_OFS_PHY_CTRL, d);
      n++;
    end
    tick(2);
    cmp(32'({d[15], phyRst}), 32'h0);
    wr(`ECRU_OFS_CTRL_TWO, 32'h900);
    wr(`ECRU_OFS_BANK, 32'h3);
    wr(`ECRU_OFS_CTRL_ONE, 32'h1);
    cmp(32'({bank, receive_enable_bit}), 32'h7);
    wr(`ECRU_OFS_CTRL_TWO, 32'h910);
    tick(2);
    cmp(32'({macRst, dmaRst, cryptoRst, phyRst, transmit_only_reset, receive_only_reset}), 32'h3f);
    wait_quiet();
    rd(`ECRU_OFS_CTRL_TWO, d);
    cmp(d & 32'hf70, 32'h900);
    cmp(32'({bank, receive_enable_bit, serAct, cfgAct}), 32'h0d);
    wr(8'h14, 32'h1);
    cmp(32'(lastResp), 32'(`ECRU_RESP_SLVERR));
    rd(8'h14, d);
    cmp(32'(lastResp), 32'(`ECRU_RESP_SLVERR));
    clkEn <= 1'b0;
    rst <= 1'b1;
    tick(3);
    cmp(32'({freq, transmit_only_reset, receive_only_reset, macRst, phyRst}), 32'h1f);
    report_and_stop();
  end
endmodule
`default_nettype wire
